// ===== verilog/abt_pkg.sv
// Constants and types shared by the break transmitter files
package abt_pkg;
  // ----------------------------------------------------------------
  // Frame lengths in bit times
  // ----------------------------------------------------------------
  localparam int BREAK_BITS_SHORT = 10;
  localparam int BREAK_BITS_LONG = 11;
  localparam logic [3:0] BITS_SHORT = 4'hA;
  localparam logic [3:0] BITS_LONG = 4'hB;
  // ----------------------------------------------------------------
  // Clock and rate
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_DEFAULT = 19200;
  localparam int BAUD_DIV_DEFAULT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam int DIV_W = 16;
  // ----------------------------------------------------------------
  // Line levels and reset values
  // ----------------------------------------------------------------
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_BREAK = 1'b0;
  localparam logic [3:0] BITCNT_RESET = 4'h0;
  localparam logic [DIV_W-1:0] DIVCNT_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // Transmitter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_READY = 2'b01,
    ST_IDLE  = 2'b10,
    ST_BREAK = 2'b11
  } abt_state_e;
  // Frame request kinds carried in the buffer
  localparam logic REQ_IDLE = 1'b0;
  localparam logic REQ_BREAK = 1'b1;
endpackage

// ===== verilog/abt_req_if.sv
// Interface carrying frame requests between buffer and transmitter
`timescale 1ns/1ps
interface abt_req_if;
  logic valid;
  logic ready;
  logic kind;
  modport src (output valid, output kind, input ready);
  modport dst (input valid, input kind, output ready);
endinterface

// ===== verilog/abt_buf2.sv
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/1ps
module abt_buf2 (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  input wire logic in_kind,
  output logic in_ready,
  // Draining side
  abt_req_if.src out
);
  logic [1:0] mem_reg;
  logic [1:0] mem_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;

  // Occupancy and shift storage
  always_comb begin
    push = in_valid && (cnt_reg != 2'h2);
    pop = out.ready && (cnt_reg != 2'h0);
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      mem_next[0] = mem_reg[1];
    end
    if (push) begin
      if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
        mem_next[0] = in_kind;
      end else begin
        mem_next[1] = in_kind;
      end
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  // Register the buffer state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
    end
  end

  assign in_ready = (cnt_reg != 2'h2);
  assign out.valid = (cnt_reg != 2'h0);
  assign out.kind = mem_reg[0];
endmodule

// ===== verilog/abt_break_tx.sv
// Break and idle frame generator for the serial transmit line
`timescale 1ns/1ps
// What this block does
// - Setting then clearing break request sends exactly one break frame.
// - Break lasts 10 bit times with short words, 11 with long words.
// - While break request stays set, break frames follow back to back.
// - Enable low then high queues one marking idle frame first.
module abt_break_tx #(
  parameter int BAUD_DIV = abt_pkg::BAUD_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Software control bits
  input wire logic BREAK_REQUEST_BIT,
  input wire logic TRANSMITTER_ENABLE_BIT,
  input wire logic WORD_LENGTH_BIT,
  // Serial line and status
  output logic TX_LINE,
  output logic TX_BUSY,
  output logic REQ_STALL
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Last divider count inside one bit time
  localparam logic [abt_pkg::DIV_W-1:0] DIV_LAST =
    abt_pkg::DIV_W'(BAUD_DIV - 1);
  abt_pkg::abt_state_e state_reg, state_next;
  logic [abt_pkg::DIV_W-1:0] div_reg, div_next;
  logic [3:0] bit_reg, bit_next;
  logic [3:0] len_reg, len_next;
  logic line_reg, line_next;
  logic busy_reg, busy_next;
  logic stall_reg, stall_next;
  logic brk_d_reg, brk_d_next;
  logic te_d_reg, te_d_next;
  logic brk_pend_reg, brk_pend_next;
  logic idle_pend_reg, idle_pend_next;
  logic bit_tick;
  logic frame_end;
  logic in_valid;
  logic in_kind;
  logic in_ready;
  abt_req_if req ();

  // Frame length from word length
  function automatic logic [3:0] frame_bits(input logic long_word);
    frame_bits = long_word ? abt_pkg::BITS_LONG : abt_pkg::BITS_SHORT;
  endfunction

  // States that put a frame on the line, for the tick and busy flag
  function automatic logic in_frame(input abt_pkg::abt_state_e st);
    in_frame = (st == abt_pkg::ST_IDLE) || (st == abt_pkg::ST_BREAK);
  endfunction

  // ----------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------
  // Two entries absorb an idle and a break queued back to back
  abt_buf2 u_buf (
    .clk(CLK_SYS),
    .nrst(NRST),
    .in_valid(in_valid),
    .in_kind(in_kind),
    .in_ready(in_ready),
    .out(req)
  );

  // Idle request wins the slot ahead of a break
  always_comb begin
    in_valid = idle_pend_reg || brk_pend_reg;
    in_kind = idle_pend_reg ? abt_pkg::REQ_IDLE : abt_pkg::REQ_BREAK;
  end

  // ----------------------------------------------------------------
  // Control bit capture
  // ----------------------------------------------------------------
  // Control bits come from logic on this clock: no synchroniser
  // One pending flag per kind holds a request until the buffer has
  // room, so a full buffer delays a request and never drops it
  // A new edge in the hand-over cycle keeps its flag set
  // Idle flag goes first so an idle line leads a break

  // Next values of the edge detectors and pending flags
  always_comb begin
    brk_d_next = BREAK_REQUEST_BIT;
    te_d_next = TRANSMITTER_ENABLE_BIT;
    brk_pend_next = brk_pend_reg;
    idle_pend_next = idle_pend_reg;
    // Flag handed to the buffer, idle ahead of break
    if (in_valid && in_ready) begin
      if (idle_pend_reg) begin
        idle_pend_next = 1'b0;
      end else begin
        brk_pend_next = 1'b0;
      end
    end
    // Set edge of break request queues one break
    if (BREAK_REQUEST_BIT && !brk_d_reg && TRANSMITTER_ENABLE_BIT) begin
      brk_pend_next = 1'b1;
    end
    // Enable rising edge queues an idle frame
    if (TRANSMITTER_ENABLE_BIT && !te_d_reg) begin
      idle_pend_next = 1'b1;
    end
  end

  // Register the edge detectors and pending flags
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      brk_d_reg <= 1'b0;
      te_d_reg <= 1'b0;
      brk_pend_reg <= 1'b0;
      idle_pend_reg <= 1'b0;
    end else begin
      brk_d_reg <= brk_d_next;
      te_d_reg <= te_d_next;
      brk_pend_reg <= brk_pend_next;
      idle_pend_reg <= idle_pend_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  // One bit time is BAUD_DIV clocks; the frame ends on the last
  // count of its last bit
  assign bit_tick = in_frame(state_reg) && (div_reg == DIV_LAST);
  assign frame_end = bit_tick && (bit_reg == len_reg - 4'h1);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    len_next = len_reg;
    line_next = abt_pkg::LINE_IDLE;
    req.ready = 1'b0;
    case (state_reg)
      abt_pkg::ST_OFF: begin
        if (TRANSMITTER_ENABLE_BIT) begin
          state_next = abt_pkg::ST_READY;
        end
      end
      abt_pkg::ST_READY: begin
        // Enable low parks the transmitter, queued requests wait
        // Oldest request starts; word length is taken here and when a held break chains
        if (!TRANSMITTER_ENABLE_BIT) begin
          state_next = abt_pkg::ST_OFF;
        end else if (req.valid) begin
          req.ready = 1'b1;
          div_next = abt_pkg::DIVCNT_RESET;
          bit_next = abt_pkg::BITCNT_RESET;
          len_next = frame_bits(WORD_LENGTH_BIT);
          if (req.kind == abt_pkg::REQ_BREAK) begin
            state_next = abt_pkg::ST_BREAK;
            line_next = abt_pkg::LINE_BREAK;
          end else begin
            state_next = abt_pkg::ST_IDLE;
          end
        end
      end
      abt_pkg::ST_IDLE, abt_pkg::ST_BREAK: begin
        line_next = (state_reg == abt_pkg::ST_BREAK) ?
          abt_pkg::LINE_BREAK : abt_pkg::LINE_IDLE;
        // Divider and bit counter run only inside a frame
        div_next = bit_tick ? abt_pkg::DIVCNT_RESET : div_reg + 1'b1;
        if (bit_tick) begin
          bit_next = bit_reg + 4'h1;
        end
        if (frame_end) begin
          // Held request chains the next break with no gap; an idle request
          // still in its pending flag or a low enable ends the chain
          bit_next = abt_pkg::BITCNT_RESET;
          if (state_reg == abt_pkg::ST_BREAK && BREAK_REQUEST_BIT &&
              TRANSMITTER_ENABLE_BIT && !idle_pend_reg) begin
            len_next = frame_bits(WORD_LENGTH_BIT);
          end else begin
            state_next = abt_pkg::ST_READY;
            line_next = abt_pkg::LINE_IDLE;
          end
        end
      end
      default: begin
        state_next = abt_pkg::ST_OFF;
      end
    endcase
    // Busy follows the next state and stall the current full buffer, so both leave flip-flops
    busy_next = in_frame(state_next);
    stall_next = in_valid && !in_ready;
  end

  // Register the sequencer
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_reg <= abt_pkg::ST_OFF;
      div_reg <= abt_pkg::DIVCNT_RESET;
      bit_reg <= abt_pkg::BITCNT_RESET;
      len_reg <= abt_pkg::BITS_SHORT;
      line_reg <= abt_pkg::LINE_IDLE;
      busy_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      len_reg <= len_next;
      line_reg <= line_next;
      busy_reg <= busy_next;
      stall_reg <= stall_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs come straight from the registers
  assign TX_LINE = line_reg;
  assign TX_BUSY = busy_reg;
  assign REQ_STALL = stall_reg;
endmodule

// ===== test/abt_break_props.sv
// Checker of break transmitter port timing
`timescale 1ns/1ps
module abt_break_props #(
  parameter int BAUD_DIV = 4
) (
  // Watched ports
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic BREAK_REQUEST_BIT,
  input wire logic TRANSMITTER_ENABLE_BIT,
  input wire logic WORD_LENGTH_BIT,
  input wire logic TX_LINE,
  input wire logic TX_BUSY
);
  localparam int FR_MAX = 11 * BAUD_DIV;
  int low_cnt;
  int frame;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Length of the current low run
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST)
      low_cnt <= 0;
    else
      low_cnt <= TX_LINE ? 0 : low_cnt + 1;
  end
  assign frame = WORD_LENGTH_BIT ? 11 * BAUD_DIV : 10 * BAUD_DIV;
  line_idle_a: assert property (!TX_BUSY |-> TX_LINE)
    else $error("line low while not busy");
  low_busy_a: assert property (!TX_LINE |-> TX_BUSY)
    else $error("line low without busy");
  break_len_a: assert property ($rose(TX_LINE) |->
    low_cnt != 0 && low_cnt % frame == 0) else $error("bad break length");
  break_end_a: assert property (!BREAK_REQUEST_BIT && !TX_LINE
    |-> ##[0:FR_MAX] TX_LINE) else $error("break did not end");
  break_repeat_a: assert property (!TX_LINE && BREAK_REQUEST_BIT &&
    TRANSMITTER_ENABLE_BIT |=> !TX_LINE) else $error("held break gap");
  break_start_a: assert property ($rose(BREAK_REQUEST_BIT) &&
    TRANSMITTER_ENABLE_BIT && $past(TRANSMITTER_ENABLE_BIT, 4) && !TX_BUSY
    |-> ##[1:4] !TX_LINE) else $error("break did not start");
  idle_first_a: assert property ($rose(TRANSMITTER_ENABLE_BIT) &&
    !TX_BUSY |-> ##[1:4] (TX_BUSY && TX_LINE)) else $error("no idle frame");
  cover property ($rose(TX_LINE) && WORD_LENGTH_BIT);
  cover property ($rose(TX_BUSY) && TX_LINE);
  cover property (low_cnt > FR_MAX);
endmodule
bind abt_break_tx abt_break_props #(.BAUD_DIV(BAUD_DIV)) abt_break_props_i (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .BREAK_REQUEST_BIT(BREAK_REQUEST_BIT),
  .TRANSMITTER_ENABLE_BIT(TRANSMITTER_ENABLE_BIT),
  .WORD_LENGTH_BIT(WORD_LENGTH_BIT), .TX_LINE(TX_LINE), .TX_BUSY(TX_BUSY));

// ===== test/abt_rx_model.sv
// Remote receiver model that times low runs on the line
`timescale 1ns/1ps
module abt_rx_model (
  // Clock, reset and line
  input wire logic clk,
  input wire logic nrst,
  input wire logic line,
  // Measured runs
  output logic [15:0] last_low,
  output logic [7:0] n_runs
);
  logic [15:0] run_reg;
  // Count low cycles, record the run when the line returns high
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_reg <= 16'h0000;
      last_low <= 16'h0000;
      n_runs <= 8'h00;
    end else if (!line) begin
      run_reg <= run_reg + 16'h0001;
    end else if (run_reg != 16'h0000) begin
      last_low <= run_reg;
      n_runs <= n_runs + 8'h01;
      run_reg <= 16'h0000;
    end
  end
endmodule

// ===== test/tb_top.sv
// Testbench for the break transmitter
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 4;
  logic clk, nrst, brk, en, wl, tx_line, tx_busy, stall;
  logic [15:0] last_low;
  logic [7:0] n_runs, n0;
  int n_fail, compares, cyc;
  abt_break_tx #(.BAUD_DIV(DIV)) abt_break_tx_i (.CLK_SYS(clk), .NRST(nrst),
    .BREAK_REQUEST_BIT(brk), .TRANSMITTER_ENABLE_BIT(en),
    .WORD_LENGTH_BIT(wl), .TX_LINE(tx_line), .TX_BUSY(tx_busy),
    .REQ_STALL(stall));
  abt_rx_model abt_rx_model_i (.clk(clk), .nrst(nrst), .line(tx_line),
    .last_low(last_low), .n_runs(n_runs));
  always #10 clk = ~clk;
  task automatic check(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Let a frame start, then wait for the line to settle idle
  task automatic wait_idle();
    repeat (6) @(negedge clk);
    for (int i = 0; i < 400 && !(tx_line === 1'b1 && tx_busy === 1'b0); i++)
      @(negedge clk);
    // One more edge lets the receiver model record the last run
    @(negedge clk);
    check("idle", {15'h0000, tx_busy}, 16'h0000);
  endtask
  task automatic pulse_break(input int hold);
    n0 = n_runs;
    brk = 1'b1;
    repeat (hold) @(negedge clk);
    brk = 1'b0;
  endtask
  task automatic t_single(input logic w);
    wl = w;
    pulse_break(2);
    wait_idle();
    check("length", last_low, 16'(w ? 11 * DIV : 10 * DIV));
    check("count", {8'h00, n_runs - n0}, 16'h0001);
    $display("Single break test done");
  endtask
  task automatic t_held();
    wl = 1'b0;
    pulse_break(25 * DIV);
    wait_idle();
    check("held length", last_low, 16'(30 * DIV));
    check("held runs", {8'h00, n_runs - n0}, 16'h0001);
    $display("Held break test done");
  endtask
  task automatic t_idle_break();
    int idle_n;
    en = 1'b0;
    pulse_break(3);
    repeat (12 * DIV) @(negedge clk);
    check("refused", {8'h00, n_runs - n0}, 16'h0000);
    en = 1'b1;
    @(negedge clk);
    pulse_break(2);
    idle_n = 0;
    for (int i = 0; i < 200 && tx_line !== 1'b0; i++) begin
      if (tx_busy === 1'b1 && tx_line === 1'b1)
        idle_n++;
      @(negedge clk);
    end
    check("idle frame", 16'(idle_n), 16'(10 * DIV));
    wait_idle();
    check("break after idle", last_low, 16'(10 * DIV));
    $display("Idle then break test done");
  endtask
  // Fill the buffer during a break so a third request must wait
  task automatic t_stall();
    wl = 1'b0;
    pulse_break(2);
    repeat (4) @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    en = 1'b1;
    @(negedge clk);
    pulse_break(1);
    en = 1'b0;
    @(negedge clk);
    en = 1'b1;
    repeat (3) @(negedge clk);
    check("stall", {15'h0000, stall}, 16'h0001);
    repeat (160) @(negedge clk);
    check("queued runs", {8'h00, n_runs - n0}, 16'h0002);
    check("stall end", {15'h0000, stall}, 16'h0000);
    check("drained", {15'h0000, tx_busy}, 16'h0000);
    $display("Queued requests test done");
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    clk = 0;
    nrst = 0;
    {brk, en, wl} = 3'h0;
    {n_fail, compares, cyc} = 0;
    repeat (4) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    en = 1'b1;
    wait_idle();
    t_single(1'b0);
    t_single(1'b1);
    t_held();
    t_idle_break();
    t_stall();
    stop_test();
  end
endmodule
